// ==== verilog/fccu_top.sv ====
// fccu_top: control command unit of a floppy controller
// (recalibrate, seek, sense interrupt, sense drive, specify, invalid)
// assumes a host on the byte port and one drive bus shared by four drives
`timescale 1ns/1ns
module fccu_top #(
	parameter int STEP_UNIT = fccu_pkg::STEP_UNIT_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      reset,
	input  wire logic [1:0]                addr,
	input  wire logic [7:0]                wdata,
	input  wire logic                      wr_en,
	input  wire logic                      rd_en,
	output logic      [7:0]                rdata,
	output logic                           irq,
	input  wire fccu_pkg::fccu_drive_in_t  drive_in,
	output fccu_pkg::fccu_drive_out_t      drive_out,
	output fccu_pkg::fccu_spec_t           spec
);
	import fccu_pkg::*;

	typedef struct packed {
		fccu_phase_t     phase;
		logic [7:0]      opcode;
		logic [7:0]      arg1;
		logic            idx;
		logic [1:0]      res_cnt;
		logic [1:0][7:0] res;
		logic [7:0]      rdata;
		fccu_spec_t      spec;
		logic [3:0][7:0] present_cylinder;
		logic [3:0][7:0] new_cylinder;
		logic [3:0][6:0] nsteps;
		logic [3:0]      active;
		logic [3:0]      recal;
		logic [3:0]      pend;
		logic [3:0]      abn;
		logic [3:0]      hd;
		fccu_eng_t       eng;
		logic [1:0]      edrv;
		logic [1:0]      settle;
		logic            dir_n;
		logic [1:0]      cdrv;
		logic            chead;
	} fccu_main_s_t;

	fccu_main_s_t   s_reg;
	fccu_main_s_t   s_next;
	fccu_drive_in_t din;
	logic           step_start;
	logic           stp_pulse;
	logic           stp_busy;
	logic           stp_done;
	logic           exec_go;
	logic [7:0]     exec_op;
	logic [7:0]     exec_sel;
	logic [7:0]     exec_last;
	logic [1:0]     exec_drv;
	logic [3:0]     fin;
	logic [7:0]     msr;

	// parameter bytes that follow each opcode; zero for unknown codes
	function automatic logic [1:0] fccu_nargs(input logic [7:0] op);
		unique case (op)
			OP_RECAL, OP_SENSE_DRV: return 2'h1;
			OP_SEEK, OP_SPECIFY:    return 2'h2;
			default:                return 2'h0;
		endcase
	endfunction : fccu_nargs

	// next drive after last with work pending, round robin
	function automatic logic [1:0] fccu_pick(input logic [3:0] act, input logic [1:0] last);
		logic [1:0] k;
		logic [1:0] r;
		r = last;
		for (int i = 1; i <= 4; i++) begin
			k = 2'(int'(last) + i);
			if (act[k] && r == last && !act[last]) begin
				r = k;
			end else if (act[k] && r == last && k != last && i < 4) begin
				r = k;
			end
		end
		return r;
	endfunction : fccu_pick

	////////////////////////////////////////////////////////////////////////
	fccu_sync #(
		.W ($bits(fccu_drive_in_t))
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     (drive_in),
		.q     (din)
	);

	fccu_stepper #(
		.UNIT_CYC  (STEP_UNIT),
		.PULSE_CYC (STEP_PULSE_CYC)
	) u_step (
		.clk        (clk),
		.reset      (reset),
		.start      (step_start),
		.interval   (s_reg.spec.step_interval_setting),
		.step_pulse (stp_pulse),
		.busy       (stp_busy),
		.done       (stp_done)
	);

	// ready always set: every byte is taken in one cycle
	always_comb begin
		msr           = 8'h00;
		msr[MSR_RQM]  = 1'b1;
		msr[MSR_DIO]  = (s_reg.phase == P_RESULT);
		msr[MSR_BUSY] = (s_reg.phase != P_IDLE);
		msr[3:0]      = s_reg.active;
	end

	////////////////////////////////////////////////////////////////////////
	// command bytes, result bytes and the shared step engine
	always_comb begin
		fccu_st0_t st0;
		logic [1:0] d;
		logic       found;
		st0        = '0;
		d          = 2'h0;
		found      = 1'b0;
		s_next     = s_reg;
		step_start = 1'b0;
		exec_go    = 1'b0;
		exec_op    = s_reg.opcode;
		exec_last  = wdata;
		fin        = 4'h0;

		// engine: one drive at a time, shared stepper
		unique case (s_reg.eng)
			E_IDLE: begin
				if (s_reg.active != 4'h0) begin
					s_next.edrv   = fccu_pick(s_reg.active, s_reg.edrv);
					s_next.settle = SEL_SETTLE;
					s_next.eng    = E_SEL;
				end
			end
			E_SEL: begin
				// let the synchronised inputs follow the new select
				s_next.settle = s_reg.settle - 1'b1;
				if (s_reg.settle == 2'h0) begin
					s_next.eng = E_EVAL;
				end
			end
			E_EVAL: begin
				s_next.eng = E_IDLE;
				if (s_reg.active[s_reg.edrv] && s_reg.recal[s_reg.edrv]) begin
					if (din.track_zero_n) begin
						fin[s_reg.edrv] = 1'b1;
						s_next.abn[s_reg.edrv] = 1'b0;
					end else if (s_reg.nsteps[s_reg.edrv] == RECAL_MAX_STEPS) begin
						fin[s_reg.edrv] = 1'b1;
						s_next.abn[s_reg.edrv] = 1'b1;
					end else begin
						s_next.dir_n = 1'b0;
						step_start   = 1'b1;
						s_next.nsteps[s_reg.edrv] = s_reg.nsteps[s_reg.edrv] + 1'b1;
						s_next.eng   = E_STEP;
					end
				end else if (s_reg.active[s_reg.edrv]) begin
					if (s_reg.present_cylinder[s_reg.edrv] < s_reg.new_cylinder[s_reg.edrv]) begin
						s_next.dir_n = 1'b1;
						step_start   = 1'b1;
						s_next.present_cylinder[s_reg.edrv] = s_reg.present_cylinder[s_reg.edrv] + 1'b1;
						s_next.eng   = E_STEP;
					end else if (s_reg.present_cylinder[s_reg.edrv] > s_reg.new_cylinder[s_reg.edrv]) begin
						s_next.dir_n = 1'b0;
						step_start   = 1'b1;
						s_next.present_cylinder[s_reg.edrv] = s_reg.present_cylinder[s_reg.edrv] - 1'b1;
						s_next.eng   = E_STEP;
					end else begin
						fin[s_reg.edrv] = 1'b1;
						s_next.abn[s_reg.edrv] = 1'b0;
					end
				end
			end
			E_STEP: begin
				// next pulse only after the programmed interval
				if (stp_done) begin
					s_next.eng = E_IDLE;
				end
			end
		endcase
		s_next.active = s_next.active & ~fin;

		// result byte read pops the queue
		s_next.rdata = 8'h00;
		if (rd_en && addr == ADDR_MSR) begin
			s_next.rdata = msr;
		end else if (rd_en && addr == ADDR_DATA && s_reg.phase == P_RESULT) begin
			s_next.rdata   = s_reg.res[0];
			s_next.res[0]  = s_reg.res[1];
			s_next.res_cnt = s_reg.res_cnt - 1'b1;
			if (s_reg.res_cnt == 2'h1) begin
				s_next.phase = P_IDLE;
			end
		end

		// command bytes; writes in the result phase are dropped
		if (wr_en && addr == ADDR_DATA && s_reg.phase == P_IDLE) begin
			s_next.opcode = wdata;
			s_next.idx    = 1'b0;
			exec_op       = wdata;
			if (fccu_nargs(wdata) == 2'h0) begin
				exec_go = 1'b1;
			end else begin
				s_next.phase = P_PARAM;
			end
		end else if (wr_en && addr == ADDR_DATA && s_reg.phase == P_PARAM) begin
			s_next.arg1 = wdata;
			s_next.idx  = 1'b1;
			if (fccu_nargs(s_reg.opcode) == {1'b0, s_reg.idx} + 2'h1) begin
				exec_go = 1'b1;
			end
		end
		exec_sel = (fccu_nargs(exec_op) == 2'h1) ? exec_last : s_reg.arg1;
		exec_drv = exec_sel[1:0];

		if (exec_go) begin
			s_next.phase = P_IDLE;
			unique case (exec_op)
				OP_RECAL: begin
					s_next.cdrv             = exec_drv;
					s_next.present_cylinder[exec_drv]    = 8'h00;
					s_next.nsteps[exec_drv] = 7'h00;
					s_next.active[exec_drv] = 1'b1;
					s_next.recal[exec_drv]  = 1'b1;
					s_next.hd[exec_drv]     = 1'b0;
					s_next.pend[exec_drv]   = 1'b0;
				end
				OP_SEEK: begin
					s_next.cdrv             = exec_drv;
					s_next.chead            = exec_sel[SEL_HEAD_BIT];
					s_next.new_cylinder[exec_drv]    = exec_last;
					s_next.active[exec_drv] = 1'b1;
					s_next.recal[exec_drv]  = 1'b0;
					s_next.hd[exec_drv]     = exec_sel[SEL_HEAD_BIT];
					s_next.pend[exec_drv]   = 1'b0;
				end
				OP_SENSE_INT: begin
					for (int i = 3; i >= 0; i--) begin
						if (s_reg.pend[i]) begin
							d     = 2'(i);
							found = 1'b1;
						end
					end
					st0.seek_end_flag   = found;
					st0.completion_code = !found ? IC_POLL : s_reg.abn[d] ? IC_ABNORMAL : IC_NORMAL;
					st0.equipment_check_flag = found && s_reg.recal[d];
					st0.head_select     = s_reg.hd[d];
					st0.drive_sel       = d;
					s_next.res[0]       = st0;
					s_next.res[1]       = s_reg.present_cylinder[d];
					s_next.res_cnt      = 2'h2;
					s_next.phase        = P_RESULT;
					if (found) begin
						s_next.pend[d] = 1'b0;
					end
				end
				OP_SENSE_DRV: begin
					// no execution phase: inputs as seen now
					s_next.cdrv    = exec_drv;
					s_next.chead   = exec_sel[SEL_HEAD_BIT];
					s_next.res[0]  = {din.fault, din.write_protect, din.ready, !din.track_zero_n,
						din.two_side, exec_sel[SEL_HEAD_BIT], exec_drv};
					s_next.res_cnt = 2'h1;
					s_next.phase   = P_RESULT;
				end
				OP_SPECIFY: begin
					s_next.spec = {s_reg.arg1, exec_last};
				end
				default: begin
					s_next.res[0]  = ST0_INVALID;
					s_next.res_cnt = 2'h1;
					s_next.phase   = P_RESULT;
				end
			endcase
		end
		// engine finish beats a clear in the same cycle
		s_next.pend = s_next.pend | fin;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg      <= '0;
			s_reg.spec <= SPEC_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs: select follows the engine while it owns the drive bus
	assign rdata = s_reg.rdata;
	assign irq   = |s_reg.pend;
	assign spec  = s_reg.spec;
	assign drive_out.drive_sel        = (s_reg.eng != E_IDLE) ? s_reg.edrv : s_reg.cdrv;
	assign drive_out.head_sel         = (s_reg.eng != E_IDLE) ? s_reg.hd[s_reg.edrv] : s_reg.chead;
	assign drive_out.step_pulse       = stp_pulse;
	assign drive_out.step_direction_n = s_reg.dir_n;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_recal_clear;
		exec_go && exec_op == OP_RECAL |=> s_reg.present_cylinder[$past(exec_drv)] == 8'h00;
	endproperty
	a_recal_clear: assert property (p_recal_clear) else $error("recal left cylinder");

	property p_recal_dir;
		step_start && s_reg.recal[s_reg.edrv] |=> !drive_out.step_direction_n ##1 stp_pulse;
	endproperty
	a_recal_dir: assert property (p_recal_dir) else $error("recal step not outward");

	property p_recal_limit;
		step_start && s_reg.recal[s_reg.edrv] |-> s_reg.nsteps[s_reg.edrv] < RECAL_MAX_STEPS;
	endproperty
	a_recal_limit: assert property (p_recal_limit) else $error("recal over step limit");

	property p_seek_dir;
		step_start && !s_reg.recal[s_reg.edrv] && s_reg.present_cylinder[s_reg.edrv] < s_reg.new_cylinder[s_reg.edrv]
			|=> drive_out.step_direction_n;
	endproperty
	a_seek_dir: assert property (p_seek_dir) else $error("seek direction wrong");

	property p_step_space;
		step_start |=> (!step_start && stp_busy) [*8];
	endproperty
	a_step_space: assert property (p_step_space) else $error("steps too close");

	property p_seek_end;
		s_reg.eng == E_EVAL && s_reg.active[s_reg.edrv] && !s_reg.recal[s_reg.edrv]
			&& s_reg.present_cylinder[s_reg.edrv] == s_reg.new_cylinder[s_reg.edrv] |=> irq && !drive_out.step_pulse;
	endproperty
	a_seek_end: assert property (p_seek_end) else $error("seek end not flagged");

	property p_busy_free;
		exec_go && exec_op == OP_SEEK |=> !msr[MSR_BUSY] && msr[MSR_RQM];
	endproperty
	a_busy_free: assert property (p_busy_free) else $error("busy after seek bytes");

	property p_irq_clear;
		exec_go && exec_op == OP_SENSE_INT && $onehot(s_reg.pend) && fin == 4'h0 |=> !irq;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

	property p_invalid;
		exec_go && fccu_nargs(exec_op) == 2'h0 && exec_op != OP_SENSE_INT && s_reg.pend == 4'h0
			&& fin == 4'h0 |=> msr[MSR_DIO] && s_reg.res[0] == ST0_INVALID && !irq;
	endproperty
	a_invalid: assert property (p_invalid) else $error("invalid opcode mishandled");

	property p_result_end;
		rd_en && addr == ADDR_DATA && s_reg.phase == P_RESULT && s_reg.res_cnt == 2'h1
			|=> s_reg.phase == P_IDLE;
	endproperty
	a_result_end: assert property (p_result_end) else $error("no return to idle");

	c_recal: cover property (exec_go && exec_op == OP_RECAL);
	c_seek_done: cover property (s_reg.eng == E_EVAL && fin != 4'h0);
	c_invalid: cover property (exec_go && fccu_nargs(exec_op) == 2'h0 && exec_op != OP_SENSE_INT);
endmodule : fccu_top

// ==== verilog/fccu_pkg.sv ====
// fccu_pkg: constants and carrier types of the floppy control command unit
// assumes one 50 MHz clock shared by every module that imports it
package fccu_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int STEP_UNIT_NS   = 1000000;
	localparam int STEP_UNIT_CYC  = STEP_UNIT_NS / CLK_PERIOD_NS;
	localparam int STEP_PULSE_NS  = 1000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SEL_SETTLE      = 2'h3;
	localparam logic [6:0] RECAL_MAX_STEPS = 7'h4D;
	localparam logic [4:0] STEP_UNITS_TOP  = 5'h10;

	// register port offsets
	localparam logic [1:0] ADDR_MSR  = 2'h0;
	localparam logic [1:0] ADDR_DATA = 2'h1;

	// opcodes
	localparam logic [7:0] OP_RECAL     = 8'h07;
	localparam logic [7:0] OP_SEEK      = 8'h0F;
	localparam logic [7:0] OP_SENSE_INT = 8'h08;
	localparam logic [7:0] OP_SENSE_DRV = 8'h04;
	localparam logic [7:0] OP_SPECIFY   = 8'h03;

	// main status bits and select byte fields
	localparam int MSR_RQM      = 7;
	localparam int MSR_DIO      = 6;
	localparam int MSR_BUSY     = 4;
	localparam int SEL_HEAD_BIT = 2;

	// status byte values
	localparam logic [1:0] IC_NORMAL   = 2'h0;
	localparam logic [1:0] IC_ABNORMAL = 2'h1;
	localparam logic [1:0] IC_POLL     = 2'h3;
	localparam logic [7:0] ST0_INVALID = 8'h80;

	typedef struct packed {
		logic fault;
		logic write_protect;
		logic ready;
		logic two_side;
		logic track_zero_n;
	} fccu_drive_in_t;

	typedef struct packed {
		logic [1:0] drive_sel;
		logic       head_sel;
		logic       step_pulse;
		logic       step_direction_n;
	} fccu_drive_out_t;

	typedef struct packed {
		logic [3:0] step_interval_setting;
		logic [3:0] unload_delay_setting;
		logic [6:0] load_delay_setting;
		logic       no_dma_select;
	} fccu_spec_t;

	localparam fccu_spec_t SPEC_RESET = 16'h0000;

	typedef struct packed {
		logic [1:0] completion_code;
		logic       seek_end_flag;
		logic       equipment_check_flag;
		logic       not_ready;
		logic       head_select;
		logic [1:0] drive_sel;
	} fccu_st0_t;

	typedef enum logic [1:0] {P_IDLE, P_PARAM, P_RESULT} fccu_phase_t;
	typedef enum logic [1:0] {E_IDLE, E_SEL, E_EVAL, E_STEP} fccu_eng_t;
endpackage : fccu_pkg

// ==== verilog/fccu_sync.sv ====
// fccu_sync: two-flop synchroniser for drive-side levels
// assumes inputs are levels from outside the clock domain
`timescale 1ns/1ns
module fccu_sync #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} fccu_sync_s_t;

	fccu_sync_s_t s_reg;
	fccu_sync_s_t s_next;

	// first stage is read only by the second
	always_comb begin
		s_next      = s_reg;
		s_next.meta = d;
		s_next.sync = s_reg.meta;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q = s_reg.sync;
endmodule : fccu_sync

// ==== verilog/fccu_stepper.sv ====
// fccu_stepper: one step pulse followed by the programmed interval
// assumes start only while busy is low
`timescale 1ns/1ns
module fccu_stepper
	import fccu_pkg::*;
#(
	parameter int UNIT_CYC  = STEP_UNIT_CYC,
	parameter int PULSE_CYC = STEP_PULSE_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic [3:0] interval,
	output logic            step_pulse,
	output logic            busy,
	output logic            done
);
	localparam int UW = $clog2(UNIT_CYC + 1);

	// pulse must end inside the first interval unit
	if (PULSE_CYC < 1 || PULSE_CYC >= UNIT_CYC) begin : g_chk
		$error("stepper pulse must be shorter than one unit");
	end

	typedef struct packed {
		logic          active;
		logic          done;
		logic [UW-1:0] pulse;
		logic [UW-1:0] unit;
		logic [4:0]    units;
	} fccu_step_s_t;

	fccu_step_s_t s_reg;
	fccu_step_s_t s_next;

	// interval is (16 - setting) units, so setting 0 is the slowest
	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		if (s_reg.pulse != '0) begin
			s_next.pulse = s_reg.pulse - 1'b1;
		end
		if (start && !s_reg.active) begin
			s_next.active = 1'b1;
			s_next.pulse  = UW'(PULSE_CYC);
			s_next.unit   = UW'(UNIT_CYC - 1);
			s_next.units  = STEP_UNITS_TOP - {1'b0, interval};
		end else if (s_reg.active) begin
			if (s_reg.unit != '0) begin
				s_next.unit = s_reg.unit - 1'b1;
			end else if (s_reg.units == 5'h01) begin
				s_next.active = 1'b0;
				s_next.done   = 1'b1;
			end else begin
				s_next.units = s_reg.units - 1'b1;
				s_next.unit  = UW'(UNIT_CYC - 1);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign step_pulse = (s_reg.pulse != '0);
	assign busy       = s_reg.active;
	assign done       = s_reg.done;
endmodule : fccu_stepper

// ==== sim/fccu_drive_model.sv ====
// fccu_drive_model: four drive heads sharing one step bus
// assumes drive_out of fccu_top; stuck holds the track zero line low
`timescale 1ns/1ns
module fccu_drive_model
	import fccu_pkg::*;
(
	input  wire logic            clk,
	input  wire fccu_drive_out_t drive_out,
	input  wire logic            stuck,
	input  wire logic [3:0]      flags,
	output fccu_drive_in_t       drive_in
);
	int   pos [4];
	int   steps;
	int   gap;
	int   cyc;
	int   last_rise;
	logic pulse_q;

	////////////////////////////////////////////////////////////////
	// heads keep their place across a controller reset, like real drives
	initial begin
		foreach (pos[i]) pos[i] = 0;
		steps = 0;
		gap = 0;
		cyc = 0;
		last_rise = 0;
		pulse_q = 1'b0;
	end

	// one cylinder per rising step edge, direction taken at that edge
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pulse_q <= drive_out.step_pulse;
		if (drive_out.step_pulse && !pulse_q) begin
			pos[drive_out.drive_sel] <= pos[drive_out.drive_sel] + (drive_out.step_direction_n ? 1 : -1);
			steps <= steps + 1;
			gap <= cyc - last_rise;
			last_rise <= cyc;
		end
	end

	// sensor high only at cylinder zero, as this block reads it
	assign drive_in = '{fault: flags[3], write_protect: flags[2], ready: flags[1], two_side: flags[0],
		track_zero_n: !stuck && pos[drive_out.drive_sel] == 0};
endmodule : fccu_drive_model

// ==== sim/fccu_top_test.sv ====
// fccu_top_test: self-checking bench for fccu_top
// assumes fccu_drive_model on the drive side, short step unit
`timescale 1ns/1ns
module fccu_top_test;
	import fccu_pkg::*;
	localparam int UNIT = 100;
	logic            clk = 1'b0;
	logic            reset = 1'b1;
	logic            wr_en = 1'b0;
	logic            rd_en = 1'b0;
	logic            stuck = 1'b0;
	logic [1:0]      addr = 2'h0;
	logic [7:0]      wdata = 8'h00;
	logic [3:0]      flags = 4'h0;
	logic [7:0]      rdata;
	logic            irq;
	fccu_drive_in_t  drive_in;
	fccu_drive_out_t drive_out;
	fccu_spec_t      spec;
	int              errors = 0;
	int              samples_checked = 0;
	int              pcn_m [4] = '{0, 0, 0, 0};
	logic [7:0]      exp_q [$];

	fccu_top #(.STEP_UNIT(UNIT)) fccu_top_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .drive_in(drive_in),
		.drive_out(drive_out), .spec(spec));
	fccu_drive_model fccu_drive_model_i (.clk(clk), .drive_out(drive_out), .stuck(stuck), .flags(flags),
		.drive_in(drive_in));

	always #10 clk = ~clk;

	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_num(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_num

	// a gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask : rd

	// drain the model queue against the data port
	task automatic results;
		logic [7:0] d;
		while (exp_q.size() > 0) begin
			rd(ADDR_DATA, d);
			chk_byte(d, exp_q.pop_front());
		end
	endtask : results

	// wait until no drive steps and a completion is pending
	task automatic wait_done;
		logic [7:0] m;
		for (int i = 0; i < 12000; i++) begin
			rd(ADDR_MSR, m);
			if (m[3:0] === 4'h0 && irq === 1'b1)
				return;
		end
		errors++;
		complete_run();
	endtask : wait_done

	task automatic sense(input int d, input logic [7:0] st0);
		wr(ADDR_DATA, OP_SENSE_INT);
		exp_q.push_back(st0);
		exp_q.push_back(8'(pcn_m[d]));
		results();
	endtask : sense

	////////////////////////////////////////////////////////////////
	initial begin
		int         st;
		int         n;
		logic       hs [2];
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] m;
		n = $urandom(32'h1307);
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		flags <= 4'($urandom);
		@(posedge clk);
		rd(ADDR_MSR, m);
		chk_byte(m, 8'h80);
		chk_byte({2'h0, irq, drive_out}, 8'h00);
		// fast interval settings keep the step times short
		st = 14 + $urandom % 2;
		b1 = {4'(st), 4'($urandom)};
		b2 = 8'($urandom);
		wr(ADDR_DATA, OP_SPECIFY);
		wr(ADDR_DATA, b1);
		wr(ADDR_DATA, b2);
		chk_byte(spec[15:8], b1);
		chk_byte(spec[7:0], b2);
		// two overlapped seeks upward
		for (int d = 0; d < 2; d++) begin
			hs[d] = 1'($urandom);
			pcn_m[d] = 3 + $urandom % 6;
			wr(ADDR_DATA, OP_SEEK);
			wr(ADDR_DATA, {5'h00, hs[d], 2'(d)});
			wr(ADDR_DATA, 8'(pcn_m[d]));
			rd(ADDR_MSR, m);
			chk_byte({6'h00, m[MSR_RQM], m[MSR_BUSY]}, 8'h02);
		end
		wait_done();
		for (int d = 0; d < 2; d++) begin
			chk_num(fccu_drive_model_i.pos[d], pcn_m[d]);
			sense(d, 8'h20 | {5'h00, hs[d], 2'(d)});
		end
		chk_byte({7'h00, irq}, 8'h00);
		// seek downward on drive 1, spacing from the interval setting
		wr(ADDR_DATA, OP_SEEK);
		wr(ADDR_DATA, {5'h00, hs[0], 2'h1});
		wr(ADDR_DATA, 8'h01);
		wait_done();
		pcn_m[1] = 1;
		n = fccu_drive_model_i.gap;
		chk_num(int'(n >= (16 - st) * UNIT && n <= (16 - st) * UNIT + 80), 1);
		chk_num(fccu_drive_model_i.pos[1], 1);
		chk_byte({5'h00, drive_out.head_sel, drive_out.drive_sel}, {5'h00, hs[0], 2'h1});
		sense(1, 8'h21 | {5'h00, hs[0], 2'h0});
		// recalibrate drive 1, sensor reached
		n = fccu_drive_model_i.steps;
		wr(ADDR_DATA, OP_RECAL);
		wr(ADDR_DATA, 8'h01);
		wait_done();
		chk_num(fccu_drive_model_i.steps - n, 1);
		pcn_m[1] = 0;
		sense(1, 8'h31);
		// recalibrate drive 2 with the sensor stuck low
		stuck <= 1'b1;
		n = fccu_drive_model_i.steps;
		wr(ADDR_DATA, OP_RECAL);
		wr(ADDR_DATA, 8'h02);
		wait_done();
		chk_num(fccu_drive_model_i.steps - n, 77);
		stuck <= 1'b0;
		sense(2, 8'h72);
		// nothing pending: polling code
		sense(0, 8'hC0);
		// undefined opcodes return one ST0_INVALID result byte
		repeat (3) begin
			wr(ADDR_DATA, 8'h10 + 8'($urandom % 8'hF0));
			rd(ADDR_MSR, m);
			chk_byte({6'h00, m[7:6]}, 8'h03);
			exp_q.push_back(ST0_INVALID);
			results();
			rd(ADDR_MSR, m);
			chk_byte(m, 8'h80);
			chk_byte({7'h00, irq}, 8'h00);
		end
		// drive status of drive 2, sensor low there
		n = $urandom % 2;
		wr(ADDR_DATA, OP_SENSE_DRV);
		wr(ADDR_DATA, {5'h00, 1'(n), 2'h2});
		exp_q.push_back({flags[3:1], 1'b1, flags[0], 1'(n), 2'h2});
		results();
		chk_byte({7'h00, irq}, 8'h00);
		complete_run();
	end
endmodule : fccu_top_test
